// *** sim/lcdrb_core_properties.sv ***
// Purpose: port checks for lcdrb_core
// Assumes: one clock, synchronous reset
// Notes:   stat trails the core by one clock
`default_nettype none
module lcdrb_core_properties
   import lcdrb_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst,
   input wire lcdrb_pkg::lcdrb_byte_t in_byte,
   input wire logic                   in_valid,
   input wire logic                   in_ready,
   input wire logic                   hw_subaddr_bit0,
   input wire logic                   hw_subaddr_bit1,
   input wire logic                   hw_subaddr_bit2,
   input wire logic [31:0]            seg_on,
   input wire logic [1:0]             bp_sel,
   input wire logic                   disp_on,
   input wire lcdrb_pkg::lcdrb_stat_t stat
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // pin age: match trails a two-flop sync
   // ----
   logic [2:0] pins;
   logic [2:0] pins_q;
   logic [2:0] age;
   assign pins = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
   always_ff @(posedge clk) begin
      pins_q <= pins;
      if (rst || pins != pins_q) begin
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   reset_clear_a: assert property (
      $fell(rst) |-> stat == '0 && seg_on == '0 && !disp_on)
      else $error("outputs not clear after reset");
   ready_up_a: assert property ($fell(rst) |=> in_ready)
      else $error("not ready after reset");
   ready_back_a: assert property (!in_ready |-> ##[1:12] in_ready)
      else $error("ready stuck low");
   ready_drop_a: assert property ($fell(in_ready) |-> $past(in_valid))
      else $error("ready fell with no push");
   match_pins_a: assert property (
      age > 3'h4 && $stable(stat.sub_cnt) |-> stat.match == (stat.sub_cnt == pins))
      else $error("match flag wrong");
   sub_carry_a: assert property (
      stat.ptr < $past(stat.ptr) && $changed(stat.sub_cnt)
      |-> stat.sub_cnt == $past(stat.sub_cnt) + 3'h1)
      else $error("subaddress carry wrong");
   blank_off_a: assert property (!disp_on && !$past(disp_on) |-> seg_on == '0)
      else $error("segments on while disabled");
   row_step_a: assert property (
      $changed(bp_sel) |-> bp_sel == $past(bp_sel) + 2'h1 || bp_sel == 2'h0)
      else $error("row order wrong");
endmodule : lcdrb_core_properties
bind lcdrb_core lcdrb_core_properties u_lcdrb_core_properties (
   .clk(clk), .rst(rst), .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
   .hw_subaddr_bit0(hw_subaddr_bit0), .hw_subaddr_bit1(hw_subaddr_bit1),
   .hw_subaddr_bit2(hw_subaddr_bit2), .seg_on(seg_on), .bp_sel(bp_sel),
   .disp_on(disp_on), .stat(stat)
);
`default_nettype wire

// *** sim/lcdrb_core_test.sv ***
// Purpose: self-checking bench for lcdrb_core
// Assumes: pins held for the whole run
// Notes:   ram read back through the row scan
`default_nettype none
module lcdrb_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lcdrb_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        slow = 1'b0;
   logic [2:0]  pins = 3'h0;
   lcdrb_byte_t in_byte;
   logic        in_valid;
   logic        in_ready;
   logic [31:0] seg_on;
   logic [1:0]  bp_sel;
   logic        disp_on;
   lcdrb_stat_t stat;
   int          seed = 32'h22f3;
   int          num_errors = 0;
   int          compares = 0;
   logic [3:0]  ram [32];
   logic [4:0]  ptr = 5'h00;
   logic [2:0]  sub = 3'h0;
   logic [1:0]  md = 2'h3;
   logic        ib = 1'b0;
   logic        ob = 1'b0;
   always #2 clk = ~clk;
   lcdrb_core u_lcdrb_core (
      .clk(clk), .rst(rst), .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
      .hw_subaddr_bit0(pins[0]), .hw_subaddr_bit1(pins[1]), .hw_subaddr_bit2(pins[2]),
      .seg_on(seg_on), .bp_sel(bp_sel), .disp_on(disp_on), .stat(stat)
   );
   lcdrb_host u_lcdrb_host (
      .clk(clk), .in_ready(in_ready), .slow(slow), .in_byte(in_byte), .in_valid(in_valid)
   );
   function automatic int step(input logic [1:0] m);
      return (m == 2'h0) ? 8 : (m == 2'h1) ? 4 : (m == 2'h2) ? 3 : 2;
   endfunction : step
   function automatic logic [1:0] phys(input logic [1:0] r);
      return (md == 2'h0) ? {ob, 1'b0} : (md == 2'h1) ? {ob, r[0]} : r;
   endfunction : phys
   function automatic logic [31:0] row_val(input logic [1:0] rr);
      for (int c = 0; c < 32; c++)
         row_val[c] = ram[c][rr];
   endfunction : row_val
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic put(input logic f, input logic [7:0] d);
      u_lcdrb_host.q.push_back({f, d});
   endtask : put
   task automatic xfer(input logic [1:0] m, input logic e, input logic i, input logic o,
                       input logic [2:0] bl, input logic [2:0] s, input logic [4:0] p);
      md = m;
      ib = i;
      ob = o;
      sub = s;
      ptr = p;
      put(1'b1, {4'hc, e, 1'b0, 2'(m + 2'h1)});
      put(1'b0, {6'h3e, i, o});
      put(1'b0, {5'h1e, bl});
      put(1'b0, {5'h1c, s});
      put(1'b0, {3'h0, p});
   endtask : xfer
   task automatic data(input logic [7:0] b);
      int n;
      n = md + 1;
      put(1'b0, b);
      for (int k = 0; k < step(md); k++)
         for (int j = 0; j < n; j++)
            if (k * n + j < 8 && sub == pins)
               ram[5'(ptr + k)][j + ((md < 2'h2) ? 2 * ib : 0)] = b[7 - (k * n + j)];
      if (ptr + step(md) > 31)
         sub = sub + 3'h1;
      ptr = 5'(ptr + step(md));
   endtask : data
   task automatic settle();
      int idle;
      int n;
      idle = 0;
      n = 0;
      while (idle < 4 && n < 400) begin
         @(negedge clk);
         n++;
         if (u_lcdrb_host.q.size() == 0 && in_valid === 1'b0 && stat.busy === 1'b0)
            idle++;
         else
            idle = 0;
      end
      chk(32'(idle), 32'h4);
   endtask : settle
   task automatic rows();
      logic [1:0] b;
      int t;
      for (int r = 0; r < 4; r++) begin
         b = bp_sel;
         t = 0;
         while (bp_sel === b && !(md == 2'h0 && b == 2'h0) && t < 100) begin
            @(negedge clk);
            t++;
         end
         chk(32'(t < 100), 32'h1);
         @(negedge clk);
         chk(seg_on, row_val(phys(bp_sel)));
      end
   endtask : rows
   task automatic hold(input logic [31:0] v, input logic eq, output int n);
      n = 0;
      while (((seg_on === v) == eq) && n < 9000) begin
         @(negedge clk);
         n++;
      end
   endtask : hold
   task automatic end_of_test();
      if (num_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      int p;
      int r;
      for (int c = 0; c < 32; c++)
         ram[c] = 4'h0;
      pins = 3'($random(seed));
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(32'(stat), 32'({(pins == 3'h0), 1'b0}));
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 3; k++) begin
            slow = 1'($random(seed));
            p = {$random(seed)} % (33 - 2 * step(2'(m)));
            xfer(2'(m), 1'b1, 1'($random(seed)), 1'b0, 3'h0, (k == 1) ? ~pins : pins, 5'(p));
            data(8'($random(seed)));
            data(8'($random(seed)));
            settle();
            chk(32'(stat.ptr), 32'(ptr));
            chk(32'(stat.sub_cnt), 32'(sub));
            xfer(2'h3, 1'b1, 1'b0, 1'b0, 3'h0, sub, ptr);
            settle();
            rows();
         end
      end
      xfer(2'h0, 1'b1, 1'b0, 1'b1, 3'h0, sub, ptr);
      settle();
      rows();
      xfer(2'h2, 1'b1, 1'b0, 1'b1, 3'h0, sub, ptr);
      settle();
      rows();
      xfer(2'h0, 1'b1, 1'b0, 1'b0, 3'h0, pins, 5'h00);
      for (int c = 0; c < 4; c++)
         data(8'hff);
      xfer(2'h0, 1'b1, 1'b1, 1'b0, 3'h0, pins, 5'h00);
      for (int c = 0; c < 4; c++)
         data(8'h5a);
      for (int m = 1; m < 4; m++) begin
         xfer(2'h0, 1'b1, 1'b0, 1'b0, 3'(m), pins, 5'h00);
         settle();
         hold(32'h0, 1'b1, r);
         hold(32'h0, 1'b0, r);
         hold(32'h0, 1'b1, r);
         chk(32'(r), 32'(BLINK_HALF << (m - 1)));
      end
      xfer(2'h0, 1'b1, 1'b0, 1'b0, 3'h5, pins, 5'h00);
      settle();
      hold(32'hffffffff, 1'b1, r);
      chk(seg_on, row_val(2'h2));
      xfer(2'h0, 1'b0, 1'b0, 1'b0, 3'h0, pins, 5'h00);
      settle();
      chk(32'(disp_on), 32'h0);
      chk(seg_on, 32'h0);
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      chk(32'h0, 32'h1);
      end_of_test();
   end
endmodule : lcdrb_core_test
`default_nettype wire

// *** sim/lcdrb_host.sv ***
// Purpose: host model feeding command and data bytes
// Assumes: bench queues bytes in transfer order
// Notes:   slow adds random gaps, so the writer also sees a lazy host
`default_nettype none
module lcdrb_host
   import lcdrb_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   in_ready,
   input  wire logic                   slow,
   output var  lcdrb_pkg::lcdrb_byte_t in_byte,
   output var  logic                   in_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   lcdrb_byte_t q[$];
   logic        taken = 1'b0;
   int          seed  = 32'h22f3;
   initial begin
      in_byte  = '0;
      in_valid = 1'b0;
   end
   always @(posedge clk) begin
      taken <= in_valid && in_ready;
   end
   // byte held until taken, queue order kept
   always @(negedge clk) begin
      if (!in_valid || taken) begin
         if (q.size() > 0 && !(slow && $random(seed) % 2 != 0)) begin
            in_byte  <= q.pop_front();
            in_valid <= 1'b1;
         end else begin
            in_valid <= 1'b0;
            in_byte  <= ~in_byte;
         end
      end
   end
endmodule : lcdrb_host
`default_nettype wire

// *** verilog/lcdrb_blink.sv ***
// Purpose: blink phase generator for the three blink rates
// Assumes: sel 0 means no blinking
// Notes:   each rate is half the previous one, so toggles cascade
`default_nettype none
module lcdrb_blink
   import lcdrb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] sel,
   output var  logic       phase
);
   logic [9:0] cnt;
   logic [2:0] tog;
   logic       wrap;

   assign wrap = cnt == 10'(BLINK_HALF - 1);

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 10'h000;
         tog <= 3'h0;
      end else begin
         cnt    <= wrap ? 10'h000 : cnt + 10'h001;
         tog[0] <= tog[0] ^ wrap;
         tog[1] <= tog[1] ^ (wrap & tog[0]);
         tog[2] <= tog[2] ^ (wrap & tog[0] & tog[1]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 1'b0;
      end else begin
         case (sel)
            2'h1:    phase <= tog[0];
            2'h2:    phase <= tog[1];
            2'h3:    phase <= tog[2];
            default: phase <= 1'b0;
         endcase
      end
   end
endmodule : lcdrb_blink
`default_nettype wire

// *** verilog/lcdrb_core.sv ***
// Purpose: display ram fill, pointer, subaddress, banks and blink
// Assumes: bytes come from a bus front end; first marks a new transfer
// Notes:   one ram word per clock, so a data byte holds the writer 2-8 clocks
//
// What this block does
// - static: eight bits into row 0
// - 1:2: bit pairs into rows 0-1
// - 1:3: triples, last word's third row untouched
// - 1:4: quadruples into rows 0-3
// - pointer command sets next byte's word
// - pointer advances 8, 4, 3 or 2
// - store only when subaddress matches pins
// - device select loads subaddress counter
// - mismatch: discard, still advance pointer
// - pointer overflow increments subaddress counter
// - output rows cycle per drive mode
// - alternate output bank shows rows 2-3
// - input bank independently targets rows 2-3
// - blink at clock over 768, 1536, 3072
// - bank swap blink in static and 1:2
// - display enable acts at once
// - stored one lights the element
// - after last command, bytes are data
`default_nettype none
module lcdrb_core (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire lcdrb_pkg::lcdrb_byte_t in_byte,
   input  wire logic                   in_valid,
   output var  logic                   in_ready,
   input  wire logic                   hw_subaddr_bit0,
   input  wire logic                   hw_subaddr_bit1,
   input  wire logic                   hw_subaddr_bit2,
   output var  logic [31:0]            seg_on,
   output var  logic [1:0]             bp_sel,
   output var  logic                   disp_on,
   output var  lcdrb_pkg::lcdrb_stat_t stat
);
   import lcdrb_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [SUB_W-1:0] sub_s1;
   logic [SUB_W-1:0] sub_s2;
   lcdrb_byte_t      b_byte;
   logic             b_valid;
   logic             b_take;
   logic             cmd_phase;
   logic             is_cmd;
   logic             take_cmd;
   logic             take_data;
   logic [7:0]       d;
   logic             c_ptr;
   logic             c_mode;
   logic             c_dev;
   logic             c_bank;
   logic             c_blink;
   lcdrb_mode_t      mode;
   logic             enable;
   logic             in_bank;
   logic             out_bank;
   logic             swap_blink;
   logic [1:0]       blink_sel;
   logic             blink_phase;
   logic             busy;
   logic [3:0]       steps;
   logic [3:0]       nsteps;
   logic [7:0]       sh;
   logic [2:0]       shift_k;
   logic [PTR_W-1:0] ptr;
   logic [SUB_W-1:0] sub_cnt;
   logic             match;
   logic             wr_go;
   logic [3:0]       wmask;
   logic [3:0]       wbits;
   logic [3:0]       ram [RAM_WORDS];
   logic [4:0]       row_tmr;
   logic [4:0]       row_len;
   logic [1:0]       row_idx;
   logic [1:0]       row_last;
   logic [1:0]       phys_row;
   logic             eff_bank;
   logic             shown;
   logic             bank_modes;

   // ----------------------------------------
   // subaddress pin synchroniser
   // ----------------------------------------
   // no reset: the strap level is settled by the first clock after reset
   always_ff @(posedge clk) begin
      sub_s1 <= {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
      sub_s2 <= sub_s1;
   end

   // ----------------------------------------
   // input buffer
   // ----------------------------------------
   lcdrb_fifo2 #(
      .W($bits(lcdrb_byte_t))
   ) u_fifo (
      .clk     (clk),
      .rst     (rst),
      .s_data  (in_byte),
      .s_valid (in_valid),
      .s_ready (in_ready),
      .m_data  (b_byte),
      .m_valid (b_valid),
      .m_ready (b_take)
   );

   // the writer takes a new byte only when the last one is stored
   assign b_take    = b_valid & ~busy;
   assign d         = b_byte.data;
   assign is_cmd    = b_byte.first | cmd_phase;
   assign take_cmd  = b_take & is_cmd;
   assign take_data = b_take & ~is_cmd;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   assign c_ptr   = take_cmd & (d[6:5] == OP_PTR);
   assign c_mode  = take_cmd & (d[6:5] == OP_MODE);
   assign c_dev   = take_cmd & (d[6:3] == OP_DEV);
   assign c_bank  = take_cmd & (d[6:2] == OP_BANK);
   assign c_blink = take_cmd & (d[6:3] == OP_BLINK);

   // a cleared continuation bit ends the command run
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_phase <= 1'b1;
      end else if (take_cmd) begin
         cmd_phase <= d[CMD_C_BIT];
      end
   end

   // ----------------------------------------
   // configuration
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         mode   <= MODE_RST;
         enable <= 1'b0;
      end else if (c_mode) begin
         enable <= d[MODE_E_BIT];
         case (d[1:0])
            MCODE_STAT: mode <= LCDRB_STATIC;
            MCODE_MUX2: mode <= LCDRB_MUX2;
            MCODE_MUX3: mode <= LCDRB_MUX3;
            default:    mode <= LCDRB_MUX4;
         endcase
      end
   end

   // input and output bank are separate flops
   always_ff @(posedge clk) begin
      if (rst) begin
         in_bank  <= 1'b0;
         out_bank <= 1'b0;
      end else if (c_bank) begin
         in_bank  <= d[BANK_I_BIT];
         out_bank <= d[BANK_O_BIT];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         blink_sel  <= 2'h0;
         swap_blink <= 1'b0;
      end else if (c_blink) begin
         blink_sel  <= d[1:0];
         swap_blink <= d[BLINK_A_BIT];
      end
   end
   lcdrb_blink u_blink (
      .clk   (clk),
      .rst   (rst),
      .sel   (blink_sel),
      .phase (blink_phase)
   );

   // ----------------------------------------
   // fill order per drive mode
   // ----------------------------------------
   always_comb begin
      case (mode)
         LCDRB_STATIC: begin
            nsteps  = 4'h8;
            shift_k = 3'h1;
         end
         LCDRB_MUX2: begin
            nsteps  = 4'h4;
            shift_k = 3'h2;
         end
         LCDRB_MUX3: begin
            nsteps  = 4'h3;
            shift_k = 3'h3;
         end
         default: begin
            nsteps  = 4'h2;
            shift_k = 3'h4;
         end
      endcase
   end

   always_comb begin
      wmask = 4'h0;
      wbits = 4'h0;
      case (mode)
         LCDRB_STATIC: begin
            wmask[{in_bank, 1'b0}] = 1'b1;
            wbits[{in_bank, 1'b0}] = sh[7];
         end
         LCDRB_MUX2: begin
            wmask[{in_bank, 1'b0}] = 1'b1;
            wmask[{in_bank, 1'b1}] = 1'b1;
            wbits[{in_bank, 1'b0}] = sh[7];
            wbits[{in_bank, 1'b1}] = sh[6];
         end
         LCDRB_MUX3: begin
            // only two bits remain for the last word
            wmask = (steps == 4'h1) ? 4'h3 : 4'h7;
            wbits = {1'b0, sh[5], sh[6], sh[7]};
         end
         default: begin
            wmask = 4'hf;
            wbits = {sh[4], sh[5], sh[6], sh[7]};
         end
      endcase
   end

   // ----------------------------------------
   // write engine
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         busy  <= 1'b0;
         steps <= 4'h0;
         sh    <= 8'h00;
      end else if (take_data) begin
         busy  <= 1'b1;
         steps <= nsteps;
         sh    <= d;
      end else if (busy) begin
         busy  <= steps != 4'h1;
         steps <= steps - 4'h1;
         sh    <= sh << shift_k;
      end
   end

   // one word per clock keeps the total step equal to nsteps
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr <= PTR_RST;
      end else if (c_ptr) begin
         ptr <= d[PTR_W-1:0];
      end else if (busy) begin
         ptr <= ptr + 5'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         sub_cnt <= SUB_RST;
      end else if (c_dev) begin
         sub_cnt <= d[SUB_W-1:0];
      end else if (busy && ptr == 5'(RAM_WORDS - 1)) begin
         sub_cnt <= sub_cnt + 3'h1;
      end
   end

   // pins are assumed steady during a transfer
   assign match = sub_cnt == sub_s2;
   assign wr_go = busy & match;

   // ----------------------------------------
   // display ram
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int w = 0; w < RAM_WORDS; w++) begin
            ram[w] <= WORD_RST;
         end
      end else if (wr_go) begin
         for (int r = 0; r < ROWS; r++) begin
            if (wmask[r]) begin
               ram[ptr][r] <= wbits[r];
            end
         end
      end
   end

   // ----------------------------------------
   // output selector
   // ----------------------------------------
   // rows share one frame, so row time shrinks with more rows
   always_comb begin
      case (mode)
         LCDRB_STATIC: begin
            row_last = 2'h0;
            row_len  = 5'(FRAME_DIV);
         end
         LCDRB_MUX2: begin
            row_last = 2'h1;
            row_len  = 5'(FRAME_DIV / 2);
         end
         LCDRB_MUX3: begin
            row_last = 2'h2;
            row_len  = 5'(FRAME_DIV / 3);
         end
         default: begin
            row_last = 2'h3;
            row_len  = 5'(FRAME_DIV / 4);
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         row_tmr <= 5'h00;
         row_idx <= 2'h0;
      end else if (row_tmr + 5'h01 >= row_len) begin
         row_tmr <= 5'h00;
         row_idx <= (row_idx >= row_last) ? 2'h0 : row_idx + 2'h1;
      end else begin
         row_tmr <= row_tmr + 5'h01;
      end
   end
   assign bank_modes = (mode == LCDRB_STATIC) | (mode == LCDRB_MUX2);
   // banks only exist where rows 2-3 are spare
   assign eff_bank = bank_modes & (out_bank ^ (swap_blink & blink_phase));
   assign phys_row = bank_modes ? {eff_bank, row_idx[0]} : row_idx;
   // swap mode replaces blanking; in 1:3 and 1:4 it falls back to blanking
   assign shown = enable & ~(blink_phase & ~(swap_blink & bank_modes));

   // ----------------------------------------
   // segment and status registers
   // ----------------------------------------
   generate
      for (genvar c = 0; c < COLS; c++) begin : g_seg
         always_ff @(posedge clk) begin
            if (rst) begin
               seg_on[c] <= 1'b0;
            end else begin
               seg_on[c] <= shown & ram[c][phys_row];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         bp_sel  <= 2'h0;
         disp_on <= 1'b0;
         stat    <= '0;
      end else begin
         bp_sel       <= row_idx;
         disp_on      <= enable;
         stat.ptr     <= ptr;
         stat.sub_cnt <= sub_cnt;
         stat.match   <= match;
         stat.busy    <= busy;
      end
   end
endmodule : lcdrb_core
`default_nettype wire

// *** verilog/lcdrb_fifo2.sv ***
// Purpose: two-entry buffer between byte source and ram writer
// Assumes: source and sink on the same clock
// Notes:   s_ready is a flop so the source sees no combinational path
`default_nettype none
module lcdrb_fifo2 #(
   parameter int W = 9
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] s_data,
   input  wire logic         s_valid,
   output var  logic         s_ready,
   output var  logic [W-1:0] m_data,
   output var  logic         m_valid,
   input  wire logic         m_ready
);
   logic [1:0]   cnt;
   logic [1:0]   next_cnt;
   logic [W-1:0] slot1;
   logic         push;
   logic         pop;

   assign push    = s_valid & s_ready;
   assign pop     = m_valid & m_ready;
   assign m_valid = cnt != 2'h0;

   always_comb begin
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt     <= 2'h0;
         s_ready <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         s_ready <= next_cnt != 2'h2;
      end
   end

   // slot 0 is always the head, so the reader never muxes
   always_ff @(posedge clk) begin
      if (pop && push) begin
         if (cnt == 2'h1) begin
            m_data <= s_data;
         end else begin
            m_data <= slot1;
            slot1  <= s_data;
         end
      end else if (pop) begin
         m_data <= slot1;
      end else if (push) begin
         if (cnt == 2'h0) begin
            m_data <= s_data;
         end else begin
            slot1 <= s_data;
         end
      end
   end
endmodule : lcdrb_fifo2
`default_nettype wire

// *** verilog/lcdrb_pkg.sv ***
// Purpose: shared constants and types for the display ram block
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   command codes follow the byte layout of the command decoder
`default_nettype none
package lcdrb_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int RAM_WORDS = 32;
   localparam int PTR_W     = 5;
   localparam int SUB_W     = 3;
   localparam int ROWS      = 4;
   localparam int COLS      = 32;

   // ----------------------------------------
   // timing ratios, in display clock cycles
   // ----------------------------------------
   localparam int FRAME_DIV  = 24;
   localparam int BLINK_DIV1 = 768;
   localparam int BLINK_HALF = BLINK_DIV1 / 2;

   // ----------------------------------------
   // command byte fields
   // ----------------------------------------
   localparam int            CMD_C_BIT   = 7;
   localparam logic [1:0]    OP_PTR      = 2'h0;
   localparam logic [1:0]    OP_MODE     = 2'h2;
   localparam logic [3:0]    OP_DEV      = 4'hc;
   localparam logic [4:0]    OP_BANK     = 5'h1e;
   localparam logic [3:0]    OP_BLINK    = 4'he;
   localparam int            MODE_E_BIT  = 3;
   localparam int            BANK_I_BIT  = 1;
   localparam int            BANK_O_BIT  = 0;
   localparam int            BLINK_A_BIT = 2;
   localparam logic [1:0]    MCODE_STAT  = 2'h1;
   localparam logic [1:0]    MCODE_MUX2  = 2'h2;
   localparam logic [1:0]    MCODE_MUX3  = 2'h3;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LCDRB_STATIC,
      LCDRB_MUX2,
      LCDRB_MUX3,
      LCDRB_MUX4
   } lcdrb_mode_t;

   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } lcdrb_byte_t;

   typedef struct packed {
      logic [PTR_W-1:0] ptr;
      logic [SUB_W-1:0] sub_cnt;
      logic             match;
      logic             busy;
   } lcdrb_stat_t;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam lcdrb_mode_t      MODE_RST  = LCDRB_MUX4;
   localparam logic [PTR_W-1:0] PTR_RST   = 5'h00;
   localparam logic [SUB_W-1:0] SUB_RST   = 3'h0;
   localparam logic [3:0]       WORD_RST  = 4'h0;
endpackage : lcdrb_pkg
`default_nettype wire
